/* File: rtl/acf_front_end.sv */
// Purpose: converter front end: pdm decimation, source mixing, pcm to pdm output
// Assumes: all inputs synchronous to sys_clk; sys_clk is the 2.048 MHz modulator clock
// Notes: the same 64-bit frame drives both paths, so input and output rates match
//
// Function
// - accept one pdm bit per modulator clock from each second-order modulator
// - decimate the pdm stream into pcm words at the 32 kHz rate
// - convert incoming pcm with a digital third-order noise-shaping modulator
// - emit 64 output bits for each pcm word consumed
// - drive the h-bridge as a complementary differential pair out of reset; both legs are held low in reset
// - front-end mode selects one of eight source combinations
// - accept four sources: two microphones, induction pickup, direct audio
// - two-microphone omni sums both microphones into one signal
// - attenuate the microphone by a configurable shift when mixing other sources
// - directional mode subtracts delayed rear microphone from front microphone
// - two-mic omni adds delayed front microphone to rear microphone
`timescale 1ns/100ps
module acf_front_end import acf_pkg::*; #(
  parameter int unsigned PW = PCM_W
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // configuration
  input wire acf_cfg_s cfg,
  // modulator bitstreams
  input wire acf_pdm_s pdm_in,
  // decimated pcm towards the dsp core
  output logic [PW-1:0] pcm_out,
  output logic pcm_out_valid,
  // pcm from the dsp core, taken on the frame boundary
  input wire logic [PW-1:0] pcm_in,
  output logic pcm_in_take,
  // h-bridge drive
  output logic hb_pos,
  output logic hb_neg
);

  // ****************************************
  // decimator: boxcar integrate and dump
  // ****************************************
  // a single-stage sinc filter keeps area low; aliasing is traded for size
  logic [OSR_W-1:0] phase_q, phase_d;
  logic [OSR_W:0] cnt_q [4], cnt_d [4];
  logic signed [PW-1:0] src_q [4], src_d [4];
  logic frame_end;
  logic [3:0] pdm_bits;
  // declared here because the delay lines below shift on it
  logic pcm_valid_q, pcm_valid_d;

  assign pdm_bits = pdm_in;
  assign frame_end = (phase_q == PHASE_LAST);

  always_comb begin
    phase_d = phase_q + OSR_W'(1);
    if (srst) begin
      phase_d = '0;
    end
  end

  // source index 3..0: first mic, second mic, pickup, direct audio
  for (genvar s = 0; s < 4; s++) begin : g_dec
    always_comb begin
      // the bit of the last phase closes this frame and must not open the next
      cnt_d[s] = frame_end ? (OSR_W+1)'(0) : cnt_q[s] + (OSR_W+1)'(pdm_bits[s]);
      src_d[s] = src_q[s];
      if (frame_end) begin
        // ones count 0..64 maps to a bipolar value around zero
        src_d[s] = PW'($signed({1'b0, cnt_q[s] + (OSR_W+1)'(pdm_bits[s])})
                   - $signed({1'b0, (OSR_W+1)'(OSR/2)})) <<< (PW - OSR_W - 1);
      end
      if (srst) begin
        cnt_d[s] = '0;
        src_d[s] = '0;
      end
    end
    always_ff @(posedge sys_clk) begin
      cnt_q[s] <= cnt_d[s];
      src_q[s] <= src_d[s];
    end
  end

  // ****************************************
  // delay lines for the two-microphone modes
  // ****************************************
  logic signed [PW-1:0] first_microphone_input_dl_q [DLY_MAX], second_microphone_input_dl_q [DLY_MAX];
  logic signed [PW-1:0] first_microphone_input_dl_d [DLY_MAX], second_microphone_input_dl_d [DLY_MAX];

  for (genvar i = 0; i < DLY_MAX; i++) begin : g_dl
    // clamped so that stage 0 never names an index below the array
    localparam int PREV = (i == 0) ? 0 : i - 1;
    always_comb begin
      first_microphone_input_dl_d[i] = first_microphone_input_dl_q[i];
      second_microphone_input_dl_d[i] = second_microphone_input_dl_q[i];
      if (pcm_valid_q) begin
        first_microphone_input_dl_d[i] = (i == 0) ? src_q[3] : first_microphone_input_dl_q[PREV];
        second_microphone_input_dl_d[i] = (i == 0) ? src_q[2] : second_microphone_input_dl_q[PREV];
      end
      if (srst) begin
        first_microphone_input_dl_d[i] = '0;
        second_microphone_input_dl_d[i] = '0;
      end
    end
    always_ff @(posedge sys_clk) begin
      first_microphone_input_dl_q[i] <= first_microphone_input_dl_d[i];
      second_microphone_input_dl_q[i] <= second_microphone_input_dl_d[i];
    end
  end

  // ****************************************
  // front-end mode mixer
  // ****************************************
  logic signed [PW-1:0] mix_q, mix_d;
  logic signed [PW:0] sum;
  logic signed [PW-1:0] front, rear, front_dly, rear_dly, mic_att;

  always_comb begin
    // delay 0 uses the live sample, otherwise tap delay-1 of the history
    front = src_q[3];
    rear = src_q[2];
    front_dly = (cfg.delay == '0) ? front : first_microphone_input_dl_q[cfg.delay - DLY_W'(1)];
    rear_dly = (cfg.delay == '0) ? rear : second_microphone_input_dl_q[cfg.delay - DLY_W'(1)];
    mic_att = front >>> cfg.atten;
    // two-source sums are formed one bit wider and halved so they cannot overflow the word
    unique case (cfg.mode)
      ACF_MODE_MIC_OMNI: sum = {front[PW-1], front};
      ACF_MODE_REAR_ONLY: sum = {rear[PW-1], rear};
      ACF_MODE_DIRECTIONAL: sum = ((PW+1)'(front) - (PW+1)'(rear_dly)) >>> 1;
      ACF_MODE_TWO_MIC_OMNI: sum = ((PW+1)'(front_dly) + (PW+1)'(rear)) >>> 1;
      ACF_MODE_DIRECT_AUDIO: sum = {src_q[0][PW-1], src_q[0]};
      ACF_MODE_PICKUP: sum = {src_q[1][PW-1], src_q[1]};
      ACF_MODE_MIC_PICKUP: sum = ((PW+1)'(mic_att) + (PW+1)'(src_q[1])) >>> 1;
      ACF_MODE_MIC_DIRECT: sum = ((PW+1)'(mic_att) + (PW+1)'(src_q[0])) >>> 1;
    endcase
    pcm_valid_d = frame_end;
    mix_d = pcm_valid_q ? sum[PW-1:0] : mix_q;
    if (srst) begin
      pcm_valid_d = 1'b0;
      mix_d = '0;
    end
  end

  always_ff @(posedge sys_clk) begin
    phase_q <= phase_d;
    pcm_valid_q <= pcm_valid_d;
    mix_q <= mix_d;
  end

  logic out_valid_q, out_valid_d;
  always_comb begin
    out_valid_d = pcm_valid_q && !srst;
  end
  always_ff @(posedge sys_clk) begin
    out_valid_q <= out_valid_d;
  end
  assign pcm_out = mix_q;
  assign pcm_out_valid = out_valid_q;

  // ****************************************
  // output modulator: third-order error feedback
  // ****************************************
  // cascade of three integrators with scaled single-bit feedback; all noise
  // poles sit at 0.75 so the peak noise gain stays near 1.5, which a one-bit
  // quantiser tolerates; unit feedback everywhere would put poles outside the
  // unit circle. inputs must stay below roughly half scale
  localparam int FULL_SCALE = 2 ** (PW - 1);
  localparam int I1_SHIFT = 6;
  localparam int FB2_SH_A = 3;
  localparam int FB2_SH_B = 4;
  localparam int FB3_SH_A = 1;
  localparam int FB3_SH_B = 2;
  logic signed [PW-1:0] hold_q, hold_d;
  logic signed [ACC_W-1:0] i1_q, i2_q, i3_q, i1_d, i2_d, i3_d, fb, fb2, fb3;
  logic bit_q, bit_d, take_q, take_d;

  always_comb begin
    hold_d = frame_end ? pcm_in : hold_q;
    take_d = frame_end;
    fb = bit_q ? ACC_W'(FULL_SCALE) : ACC_W'(-FULL_SCALE);
    // feedback weights 3/16 and 3/4 from shifts; first stage weight 1/64
    fb2 = (fb >>> FB2_SH_A) + (fb >>> FB2_SH_B);
    fb3 = (fb >>> FB3_SH_A) + (fb >>> FB3_SH_B);
    i1_d = i1_q + ACC_W'(hold_q) - fb;
    i2_d = i2_q + (i1_q >>> I1_SHIFT) - fb2;
    i3_d = i3_q + i2_q - fb3;
    bit_d = !i3_d[ACC_W-1];
    if (srst) begin
      hold_d = '0;
      take_d = 1'b0;
      i1_d = '0;
      i2_d = '0;
      i3_d = '0;
      bit_d = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    hold_q <= hold_d;
    take_q <= take_d;
    i1_q <= i1_d;
    i2_q <= i2_d;
    i3_q <= i3_d;
    bit_q <= bit_d;
  end

  logic pos_q, neg_q, pos_d, neg_d;
  always_comb begin
    pos_d = bit_q;
    neg_d = !bit_q;
    if (srst) begin
      pos_d = 1'b0;
      neg_d = 1'b0;
    end
  end
  always_ff @(posedge sys_clk) begin
    pos_q <= pos_d;
    neg_q <= neg_d;
  end
  assign hb_pos = pos_q;
  assign hb_neg = neg_q;
  assign pcm_in_take = take_q;

  // ****************************************
  // checks
  // ****************************************
  valid_spacing_a: assert property (@(posedge sys_clk) disable iff (srst)
    $rose(pcm_out_valid) |=> !pcm_out_valid [*8])
    else $error("sample valid repeated too soon");
  valid_period_a: assert property (@(posedge sys_clk) disable iff (srst)
    pcm_out_valid && $past(pcm_out_valid, 1) == 1'b0 |-> ##64 pcm_out_valid)
    else $error("sample valid not every 64 clocks");
  take_period_a: assert property (@(posedge sys_clk) disable iff (srst)
    pcm_in_take |-> ##64 pcm_in_take)
    else $error("pcm word not consumed every 64 bits");
  take_phase_a: assert property (@(posedge sys_clk) disable iff (srst)
    pcm_in_take |-> ##1 pcm_out_valid)
    else $error("input and output frames out of step");
  bridge_pair_a: assert property (@(posedge sys_clk) disable iff (srst)
    ##1 !$past(srst) |-> hb_pos != hb_neg)
    else $error("h-bridge outputs not complementary");
  bridge_follow_a: assert property (@(posedge sys_clk) disable iff (srst)
    !$past(srst) |=> hb_pos == $past(bit_q))
    else $error("h-bridge not following modulator bit");
  phase_wrap_a: assert property (@(posedge sys_clk) disable iff (srst)
    frame_end |=> phase_q == '0)
    else $error("frame phase did not wrap");
  mix_hold_a: assert property (@(posedge sys_clk) disable iff (srst)
    !pcm_out_valid && !$past(pcm_valid_q) |-> $stable(pcm_out))
    else $error("pcm output changed between samples");

endmodule // acf_front_end

/* File: rtl/acf_pkg.sv */
// Purpose: shared constants and types for the audio converter front end
// Assumes: one clock, the modulator clock, with one modulator bit per edge
// Notes: pcm words are signed two's complement
package acf_pkg;

  localparam int unsigned MOD_CLK_HZ = 2048000;
  localparam int unsigned PCM_RATE_HZ = 32000;
  localparam int unsigned OSR = MOD_CLK_HZ / PCM_RATE_HZ;
  localparam int unsigned OSR_W = $clog2(OSR);
  localparam int unsigned PCM_W = 16;
  localparam int unsigned ACC_W = 24;
  localparam int unsigned DLY_MAX = 16;
  localparam int unsigned DLY_W = $clog2(DLY_MAX);
  localparam int unsigned ATT_W = 3;
  localparam logic [OSR_W-1:0] PHASE_LAST = OSR_W'(OSR - 1);

  typedef enum logic [2:0] {
    ACF_MODE_MIC_OMNI,
    ACF_MODE_REAR_ONLY,
    ACF_MODE_DIRECTIONAL,
    ACF_MODE_TWO_MIC_OMNI,
    ACF_MODE_DIRECT_AUDIO,
    ACF_MODE_PICKUP,
    ACF_MODE_MIC_PICKUP,
    ACF_MODE_MIC_DIRECT
  } acf_mode_e;

  typedef struct packed {
    logic first_microphone_input;
    logic second_microphone_input;
    logic induction_pickup_input;
    logic direct_audio_input;
  } acf_pdm_s;

  typedef struct packed {
    acf_mode_e mode;
    logic [DLY_W-1:0] delay;
    logic [ATT_W-1:0] atten;
  } acf_cfg_s;

endpackage

/* File: verification/acf_dsp_model.sv */
// Purpose: dsp core stand-in that hands pcm words to the output path
// Assumes: a word is consumed on each pcm_in_take pulse
// Notes: shows the inverse word early in a frame, as a stale bus would
`timescale 1ns/100ps
module acf_dsp_model import acf_pkg::*; (
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // word to send and its consumption
  input wire logic [PCM_W-1:0] word,
  input wire logic pcm_in_take,
  output logic [PCM_W-1:0] pcm_in
);
  int phase_q;
  always @(posedge sys_clk) begin
    if (srst || pcm_in_take) begin
      phase_q <= 0;
    end else begin
      phase_q <= phase_q + 1;
    end
  end
  assign pcm_in = (phase_q >= 32) ? word : ~word;
endmodule // acf_dsp_model

/* File: verification/tb_top.sv */
// Purpose: self-checking bench for the converter front end
// Assumes: inputs change on the falling edge
// Notes: expectations follow the boxcar (ones-32)<<9 and halved mixes
`timescale 1ns/100ps
module tb_top;
  import acf_pkg::*;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  acf_cfg_s cfg = '0;
  acf_pdm_s pdm_in = '0;
  logic alt = 1'b0;
  logic tog = 1'b0;
  logic [PCM_W-1:0] pcm_out, pcm_in;
  logic [PCM_W-1:0] word = '0;
  logic pcm_out_valid, pcm_in_take, hb_pos, hb_neg;
  int fails = 0;
  int n_compared = 0;
  int up = 0;
  always #2.5 sys_clk = ~sys_clk;
  // alt replaces the first microphone with an alternating stream, 32 ones a frame
  always @(negedge sys_clk) tog <= ~tog;
  acf_front_end #(.PW(PCM_W)) i_acf_front_end (.sys_clk(sys_clk), .srst(srst), .cfg(cfg),
    .pdm_in(alt ? acf_pdm_s'({tog, pdm_in[2:0]}) : pdm_in), .pcm_out(pcm_out),
    .pcm_out_valid(pcm_out_valid), .pcm_in(pcm_in),
    .pcm_in_take(pcm_in_take), .hb_pos(hb_pos), .hb_neg(hb_neg));
  acf_dsp_model i_acf_dsp_model (.sys_clk(sys_clk), .srst(srst), .word(word),
    .pcm_in_take(pcm_in_take), .pcm_in(pcm_in));
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    if (fails == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wait_valid(int n);
    int k;
    repeat (n) begin
      k = 0;
      do begin
        @(negedge sys_clk);
        k++;
      end while (pcm_out_valid !== 1'b1 && k < 200);
    end
  endtask
  // the drive pair stays complementary once out of reset
  always @(negedge sys_clk) begin
    up <= srst ? 0 : up + 1;
    if (up > 2) check("hb_neg", hb_neg, !hb_pos);
  end
  task automatic t_reset;
    int n;
    repeat (4) @(negedge sys_clk);
    check("reset outs", {pcm_out, pcm_out_valid, pcm_in_take, hb_pos, hb_neg}, '0);
    srst = 1'b0;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (pcm_in_take !== 1'b1 && n < 200);
    check("first take", n, 64);
    @(negedge sys_clk);
    check("valid", {pcm_out_valid, pcm_in_take}, 2'b10);
    n = 1;
    do begin
      @(negedge sys_clk);
      n++;
    end while (pcm_in_take !== 1'b1 && n < 200);
    check("spacing", n, 64);
  endtask
  task automatic mix(acf_mode_e m, logic [2:0] a, logic [15:0] exp);
    cfg = '{m, 4'h0, a};
    wait_valid(3);
    check("pcm_out", pcm_out, exp);
  endtask
  task automatic t_modes;
    logic [15:0] e[8] = '{16'h4000, 16'hc000, 16'h4000, 16'h0000,
                         16'hc000, 16'h4000, 16'h4000, 16'h0000};
    pdm_in = 4'b1010;
    for (int m = 0; m < 8; m++) mix(acf_mode_e'(m), 3'h0, e[m]);
    mix(ACF_MODE_MIC_PICKUP, 3'h1, 16'h3000);
    mix(ACF_MODE_MIC_PICKUP, 3'h7, 16'h2040);
    alt = 1'b1;
    mix(ACF_MODE_MIC_OMNI, 3'h0, 16'h0000);
    alt = 1'b0;
  endtask
  task automatic lag(acf_mode_e m, logic [3:0] d, output int k);
    logic [15:0] fin;
    fin = (m == ACF_MODE_DIRECTIONAL) ? 16'h4000 : 16'h0000;
    cfg = '{m, d, 3'h0};
    pdm_in = 4'b1100;
    wait_valid(20);
    pdm_in = (m == ACF_MODE_DIRECTIONAL) ? 4'b1000 : 4'b0100;
    k = 0;
    while (pcm_out !== fin && k < 30) begin
      wait_valid(1);
      k++;
    end
  endtask
  task automatic t_delay;
    int k0, k2;
    lag(ACF_MODE_DIRECTIONAL, 4'h0, k0);
    lag(ACF_MODE_DIRECTIONAL, 4'h2, k2);
    check("rear delay", k2 - k0, 2);
    lag(ACF_MODE_TWO_MIC_OMNI, 4'h0, k0);
    lag(ACF_MODE_TWO_MIC_OMNI, 4'h2, k2);
    check("front delay", k2 - k0, 2);
  endtask
  task automatic dac(logic [15:0] w, int exp);
    int ones, takes;
    word = w;
    wait_valid(4);
    wait_valid(0);
    while (pcm_in_take !== 1'b1) @(negedge sys_clk);
    ones = 0;
    takes = 0;
    repeat (512) begin
      @(negedge sys_clk);
      ones += hb_pos;
      takes += pcm_in_take;
    end
    check("takes", takes, 8);
    check("density", (ones > exp - 17) && (ones < exp + 17), 1);
  endtask
  initial begin
    #150000;
    fails++;
    report_and_stop;
  end
  initial begin
    t_reset;
    t_modes;
    t_delay;
    dac(16'h0000, 256);
    dac(16'h2000, 320);
    report_and_stop;
  end
endmodule // tb_top
